// [rtl/lfsr_unit_defines.svh]
// constants for the programmable lfsr unit
`ifndef LFSR_UNIT_DEFINES_SVH
`define LFSR_UNIT_DEFINES_SVH
`define WIN_HIGH_ADDR 8'h23
`define WIN_LOW_ADDR 8'h27
`define WIN_ADDR_ADDR 8'h2B
`define IDX_INPUT 4'h0
`define IDX_OUTPUT 4'h1
`define IDX_FB12 4'h2
`define IDX_CFG2_RES4 4'h3
`define IDX_RES32 4'h4
`define IDX_RES10 4'h5
`define IDX_FB34 4'h6
`define IDX_CFG3_TAP 4'h7
`define IDX_CFG1_POLY4 4'h8
`define IDX_POLY32 4'h9
`define IDX_POLY10 4'hA
`define IDX_CMP32 4'hB
`define IDX_CMP10 4'hC
`define CFG1_RESET 8'h10
`define CFG1_PRESET_BIT 6
`define CFG1_DONE_BIT 5
`define CFG1_MATCH_BIT 4
`define CFG2_TAP_STREAM_BIT 0
`define CFG2_IN_STREAM_BIT 1
`define CFG2_T1_STREAM_BIT 2
`define CFG2_T2_STREAM_BIT 3
`define CFG2_IN_ENTRY_BIT 4
`define CFG2_T1_ENTRY_BIT 5
`define CFG2_T2_ENTRY_BIT 6
`define CFG2_IN_ADD_BIT 7
`define CFG3_AUTO_BIT 0
`define CFG3_DIR_BIT 1
`define CFG3_ORDER_BIT 2
`define CFG3_TRIG_BIT 3
`define CFG3_T3_ENTRY_BIT 4
`define CFG3_T4_ENTRY_BIT 5
`define RES_RESET 40'hFFFFFFFFFF
`define CMP_RESET 32'hFFFFFFFF
`endif

// [rtl/lfsr_unit_pkg.sv]
// types for the programmable lfsr unit
`default_nettype none
package lfsr_unit_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_shift = 2'b10
  } op_state_t;
endpackage
`default_nettype wire

// [rtl/programmable_lfsr_unit.sv]
// programmable lfsr unit with byte-wide indexed register window
//
// Behaviour
// (RULE1) writing the preset bit fills remainder with ones; bit reads zero
// (RULE2) completion flag reads zero while shifting, one when finished
// (RULE3) after each operation match flag shows selected remainder equals compare value
// (RULE4) shift length N yields exactly N+1 single-bit shift steps
// (RULE5) output stream xors enabled sources: output tap, input, taps one, two
// (RULE6) entry bit xors enabled input and taps one to four
// (RULE7) four feedback selects drive 40:1 muxes for entry, add control, stream
// (RULE8) output tap select drives 40:1 mux feeding the output stream
// (RULE9) auto fill loads input word when paired serializer buffer loads
// (RULE10) direction bit picks shift direction and remainder byte mapping
// (RULE11) input order set feeds msb first, clear lsb first
// (RULE12) trigger select chooses high or low input byte write as start
// (RULE13) input word is sixteen bits from high and low bytes
// (RULE14) shifted-out bits enter output word lsb first
// (RULE15) five bytes hold the forty-bit generator polynomial
// (RULE16) five bytes hold the remainder, mapping set by direction bit
// (RULE17) compare remainder 39:8 or 0:31 against compare value by direction
// (RULE18) reset values zero except remainder, compare all ones, config one 0x10
// (RULE19) address register selects unit and pair, accessed via high/low bytes
// (RULE20) one bit per clock from the trigger while the stream buffer is not full
// (RULE21) add control one xors polynomial into the shift, else plain shift
// (RULE22) enabled sources combine by xor; none enabled gives zero
`include "lfsr_unit_defines.svh"
`default_nettype none
module programmable_lfsr_unit #(
  parameter logic [3:0] UNIT_ID = 4'h0,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clock_enable,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic serializer_load,
  input wire logic [15:0] serializer_receive_buffer,
  output logic serializer_ready,
  output logic stream_bit,
  output logic stream_valid,
  input wire logic stream_ready
);

  ////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] unit_window_address;
  logic [3:0] shift_length;
  logic match_flag;
  logic [7:0] unit_config_two;
  logic [7:0] unit_config_three;
  logic [15:0] input_word;
  logic [15:0] output_word;
  logic [7:0] output_tap_select;
  logic [7:0] feedback_tap_selects [4];
  logic [39:0] generator_coeff_bytes;
  logic [39:0] remainder;
  logic [31:0] expected_value;
  lfsr_unit_pkg::op_state_t state;
  logic done_flag;
  logic [4:0] steps_left;
  logic [3:0] bit_pos;

  wire logic remainder_direction = unit_config_three[`CFG3_DIR_BIT];
  wire logic input_order = unit_config_three[`CFG3_ORDER_BIT];
  wire logic trigger_select = unit_config_three[`CFG3_TRIG_BIT];
  wire logic auto_fill_enable = unit_config_three[`CFG3_AUTO_BIT];
  wire logic busy = (state == lfsr_unit_pkg::st_shift);

  // window decode
  wire logic [3:0] win_index = unit_window_address[3:0];
  wire logic unit_hit = (unit_window_address[5:4] == UNIT_ID[1:0]); // [RULE19]
  wire logic wr_high = bus_write && bus_addr == `WIN_HIGH_ADDR && unit_hit;
  wire logic wr_low = bus_write && bus_addr == `WIN_LOW_ADDR && unit_hit;

  function automatic logic wr_at(input logic hit, input logic [3:0] idx, input logic [3:0] want);
    wr_at = hit && idx == want;
  endfunction

  function automatic logic tap_mux(input logic [39:0] r, input logic [7:0] sel);
    tap_mux = (sel < 8'd40) ? r[sel[5:0]] : 1'b0;
  endfunction

  // remainder byte view; direction bit reverses the bit order
  function automatic logic [39:0] mapped(input logic [39:0] r, input logic dir);
    logic [39:0] m;
    m = r;
    if (dir) begin
      for (int i = 0; i < 40; i++) begin
        m[i] = r[39 - i];
      end
    end
    mapped = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // feedback and stream gating
  logic in_bit;
  logic tap [4];
  logic out_tap;
  logic entry_bit;
  logic generator_add_control;
  logic next_stream;
  logic out_bit;
  logic [39:0] next_remainder;

  always_comb begin
    in_bit = input_order ? input_word[4'd15 - bit_pos] : input_word[bit_pos]; // [RULE11]
    for (int k = 0; k < 4; k++) begin
      tap[k] = tap_mux(remainder, feedback_tap_selects[k]); // [RULE7]
    end
    out_tap = tap_mux(remainder, output_tap_select); // [RULE8]
    // [RULE22]
    entry_bit = (unit_config_two[`CFG2_IN_ENTRY_BIT] & in_bit)
      ^ (unit_config_two[`CFG2_T1_ENTRY_BIT] & tap[0])
      ^ (unit_config_two[`CFG2_T2_ENTRY_BIT] & tap[1])
      ^ (unit_config_three[`CFG3_T3_ENTRY_BIT] & tap[2])
      ^ (unit_config_three[`CFG3_T4_ENTRY_BIT] & tap[3]); // [RULE6]
    generator_add_control = (unit_config_two[`CFG2_IN_ADD_BIT] & in_bit) ^ tap[0]; // [RULE7]
    next_stream = (unit_config_two[`CFG2_TAP_STREAM_BIT] & out_tap)
      ^ (unit_config_two[`CFG2_IN_STREAM_BIT] & in_bit)
      ^ (unit_config_two[`CFG2_T1_STREAM_BIT] & tap[0])
      ^ (unit_config_two[`CFG2_T2_STREAM_BIT] & tap[1]); // [RULE5]
    // [RULE10]
    if (remainder_direction) begin
      out_bit = remainder[0];
      next_remainder = {entry_bit, remainder[39:1]};
    end else begin
      out_bit = remainder[39];
      next_remainder = {remainder[38:0], entry_bit};
    end
    if (generator_add_control) begin
      next_remainder = next_remainder ^ generator_coeff_bytes; // [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stream buffer
  logic [BUF_DEPTH-1:0] buf_data;
  logic [1:0] buf_count;
  wire logic buf_full = (buf_count == 2'(BUF_DEPTH));
  wire logic push = busy && !buf_full;
  wire logic pop = stream_valid && stream_ready;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      buf_data <= '0;
      buf_count <= 2'h0;
      stream_valid <= 1'b0;
      stream_bit <= 1'b0;
    end else if (clock_enable) begin
      logic [BUF_DEPTH-1:0] d;
      logic [1:0] c;
      d = buf_data;
      c = buf_count;
      if (pop) begin
        d = d >> 1;
        c = c - 2'h1;
      end
      if (push) begin
        d[c[0]] = next_stream;
        c = c + 2'h1;
      end
      buf_data <= d;
      buf_count <= c;
      stream_valid <= (c != 2'h0);
      stream_bit <= d[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer
  wire logic trigger = trigger_select ? wr_at(wr_high, win_index, `IDX_INPUT)
                                      : wr_at(wr_low, win_index, `IDX_INPUT); // [RULE12]
  wire logic auto_trigger = auto_fill_enable && serializer_load && !busy; // [RULE9]
  wire logic step = busy && !buf_full;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= lfsr_unit_pkg::st_idle;
      done_flag <= 1'(`CFG1_RESET >> `CFG1_DONE_BIT); // [RULE18]
      steps_left <= 5'h0;
      bit_pos <= 4'h0;
    end else if (clock_enable) begin
      case (state)
        lfsr_unit_pkg::st_idle: begin
          if (trigger || auto_trigger) begin
            state <= lfsr_unit_pkg::st_shift;
            done_flag <= 1'b0; // [RULE2]
            steps_left <= {1'b0, shift_length} + 5'h1; // [RULE4]
            bit_pos <= 4'h0;
          end
        end
        lfsr_unit_pkg::st_shift: begin
          if (step) begin
            bit_pos <= bit_pos + 4'h1; // [RULE20]
            steps_left <= steps_left - 5'h1;
            if (steps_left == 5'h1) begin
              state <= lfsr_unit_pkg::st_idle;
              done_flag <= 1'b1; // [RULE2]
            end
          end
        end
        default: begin
          state <= lfsr_unit_pkg::st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input word and serializer fill
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      input_word <= 16'h0000;
      serializer_ready <= 1'b0;
    end else if (clock_enable) begin
      serializer_ready <= !busy;
      if (auto_trigger) begin
        input_word <= serializer_receive_buffer; // [RULE9]
      end else begin
        if (wr_at(wr_high, win_index, `IDX_INPUT)) begin
          input_word[15:8] <= bus_wdata; // [RULE13]
        end
        if (wr_at(wr_low, win_index, `IDX_INPUT)) begin
          input_word[7:0] <= bus_wdata; // [RULE13]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // remainder, output word and match flag
  wire logic [39:0] rem_view = mapped(remainder, remainder_direction);
  function automatic logic [31:0] cmp_pick(input logic [39:0] r, input logic dir);
    cmp_pick = dir ? r[31:0] : r[39:8]; // [RULE17]
  endfunction

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      remainder <= `RES_RESET; // [RULE18]
      output_word <= 16'h0000;
      match_flag <= 1'(`CFG1_RESET >> `CFG1_MATCH_BIT); // [RULE18]
    end else if (clock_enable) begin
      logic [39:0] v;
      v = rem_view;
      if (step) begin
        remainder <= next_remainder;
        output_word <= {out_bit, output_word[15:1]}; // [RULE14]
        if (steps_left == 5'h1) begin
          match_flag <= cmp_pick(next_remainder, remainder_direction) == expected_value; // [RULE3]
        end
      end else if (wr_at(wr_high, win_index, `IDX_CFG1_POLY4) && bus_wdata[`CFG1_PRESET_BIT]) begin
        remainder <= `RES_RESET; // [RULE1]
      end else begin
        // [RULE16]
        if (wr_at(wr_low, win_index, `IDX_CFG2_RES4)) v[39:32] = bus_wdata;
        if (wr_at(wr_high, win_index, `IDX_RES32)) v[31:24] = bus_wdata;
        if (wr_at(wr_low, win_index, `IDX_RES32)) v[23:16] = bus_wdata;
        if (wr_at(wr_high, win_index, `IDX_RES10)) v[15:8] = bus_wdata;
        if (wr_at(wr_low, win_index, `IDX_RES10)) v[7:0] = bus_wdata;
        remainder <= mapped(v, remainder_direction);
      end
      if (wr_at(wr_high, win_index, `IDX_OUTPUT)) output_word[15:8] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_OUTPUT)) output_word[7:0] <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration and select registers
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      unit_window_address <= 8'h00;
      shift_length <= 4'(`CFG1_RESET); // [RULE18]
      unit_config_two <= 8'h00;
      unit_config_three <= 8'h00;
      output_tap_select <= 8'h00;
      for (int k = 0; k < 4; k++) feedback_tap_selects[k] <= 8'h00;
      generator_coeff_bytes <= 40'h0000000000;
      expected_value <= `CMP_RESET;
    end else if (clock_enable) begin
      if (bus_write && bus_addr == `WIN_ADDR_ADDR) unit_window_address <= bus_wdata; // [RULE19]
      if (wr_at(wr_high, win_index, `IDX_CFG1_POLY4)) shift_length <= bus_wdata[3:0];
      if (wr_at(wr_high, win_index, `IDX_CFG2_RES4)) unit_config_two <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_CFG3_TAP)) unit_config_three <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_CFG3_TAP)) output_tap_select <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_FB12)) feedback_tap_selects[0] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_FB12)) feedback_tap_selects[1] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_FB34)) feedback_tap_selects[2] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_FB34)) feedback_tap_selects[3] <= bus_wdata;
      // [RULE15]
      if (wr_at(wr_low, win_index, `IDX_CFG1_POLY4)) generator_coeff_bytes[39:32] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_POLY32)) generator_coeff_bytes[31:24] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_POLY32)) generator_coeff_bytes[23:16] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_POLY10)) generator_coeff_bytes[15:8] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_POLY10)) generator_coeff_bytes[7:0] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_CMP32)) expected_value[31:24] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_CMP32)) expected_value[23:16] <= bus_wdata;
      if (wr_at(wr_high, win_index, `IDX_CMP10)) expected_value[15:8] <= bus_wdata;
      if (wr_at(wr_low, win_index, `IDX_CMP10)) expected_value[7:0] <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  logic [7:0] rd_mux;
  logic [7:0] cfg_one_view;
  always_comb begin
    // preset bit reads zero, done reads zero while busy
    cfg_one_view = {2'b00, done_flag, match_flag, shift_length}; // [RULE1] [RULE2]
    rd_mux = 8'h00;
    if (bus_addr == `WIN_ADDR_ADDR) begin
      rd_mux = unit_window_address;
    end else if (unit_hit && bus_addr == `WIN_HIGH_ADDR) begin
      case (win_index)
        `IDX_INPUT: rd_mux = input_word[15:8];
        `IDX_OUTPUT: rd_mux = output_word[15:8];
        `IDX_FB12: rd_mux = feedback_tap_selects[1];
        `IDX_CFG2_RES4: rd_mux = unit_config_two;
        `IDX_RES32: rd_mux = rem_view[31:24];
        `IDX_RES10: rd_mux = rem_view[15:8];
        `IDX_FB34: rd_mux = feedback_tap_selects[3];
        `IDX_CFG3_TAP: rd_mux = unit_config_three;
        `IDX_CFG1_POLY4: rd_mux = cfg_one_view;
        `IDX_POLY32: rd_mux = generator_coeff_bytes[31:24];
        `IDX_POLY10: rd_mux = generator_coeff_bytes[15:8];
        `IDX_CMP32: rd_mux = expected_value[31:24];
        `IDX_CMP10: rd_mux = expected_value[15:8];
        default: rd_mux = 8'h00;
      endcase
    end else if (unit_hit && bus_addr == `WIN_LOW_ADDR) begin
      case (win_index)
        `IDX_INPUT: rd_mux = input_word[7:0];
        `IDX_OUTPUT: rd_mux = output_word[7:0];
        `IDX_FB12: rd_mux = feedback_tap_selects[0];
        `IDX_CFG2_RES4: rd_mux = rem_view[39:32];
        `IDX_RES32: rd_mux = rem_view[23:16];
        `IDX_RES10: rd_mux = rem_view[7:0];
        `IDX_FB34: rd_mux = feedback_tap_selects[2];
        `IDX_CFG3_TAP: rd_mux = output_tap_select;
        `IDX_CFG1_POLY4: rd_mux = generator_coeff_bytes[39:32];
        `IDX_POLY32: rd_mux = generator_coeff_bytes[23:16];
        `IDX_POLY10: rd_mux = generator_coeff_bytes[7:0];
        `IDX_CMP32: rd_mux = expected_value[23:16];
        `IDX_CMP10: rd_mux = expected_value[7:0];
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end else if (clock_enable) begin
      bus_rvalid <= bus_read;
      bus_rdata <= bus_read ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// [verification/programmable_lfsr_unit_chk.sv]
// assertion checker for the lfsr unit register window and stream
`default_nettype none
module programmable_lfsr_unit_chk #(
  parameter logic [3:0] UNIT_ID = 4'h0,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clock_enable,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic serializer_load,
  input wire logic [15:0] serializer_receive_buffer,
  input wire logic serializer_ready,
  input wire logic stream_bit,
  input wire logic stream_valid,
  input wire logic stream_ready
);
  logic [7:0] win;
  logic rd_cfg1;
  logic rd_off;
  // shadow of the window address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      win <= 8'h00;
    end else if (clock_enable && bus_write && bus_addr == 8'h2B) begin
      win <= bus_wdata;
    end
  end
  assign rd_cfg1 = clock_enable && bus_read && bus_addr == 8'h23 && win[5:4] == UNIT_ID[1:0] && win[3:0] == 4'h8;
  assign rd_off = clock_enable && bus_read && bus_addr != 8'h2B && (win[5:4] != UNIT_ID[1:0] || win[3:0] > 4'hC);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence idle_run;
    serializer_ready [*3];
  endsequence
  // config one read, then unit seen busy at that read edge
  sequence cfg1_read_busy;
    rd_cfg1 ##1 !serializer_ready;
  endsequence
  AST_RVALID_AFTER_READ: assert property (clock_enable && bus_read |=> bus_rvalid)
    else $error("read got no valid pulse");
  AST_RVALID_ONLY_READ: assert property (!(clock_enable && bus_read) |=> !bus_rvalid)
    else $error("valid pulse without read");
  AST_RDATA_IDLE_ZERO: assert property (!bus_rvalid |-> bus_rdata == 8'h00)
    else $error("read data not zero outside valid");
  AST_PRESET_READS_ZERO: assert property (rd_cfg1 |=> bus_rdata[7:6] == 2'b00)
    else $error("preset bit read back as one");
  AST_DONE_LOW_BUSY: assert property (cfg1_read_busy |-> !bus_rdata[5])
    else $error("completion flag high while shifting");
  AST_REFUSED_READ_ZERO: assert property (rd_off |=> bus_rvalid && bus_rdata == 8'h00)
    else $error("foreign or unused index read nonzero");
  AST_STREAM_HOLD: assert property (stream_valid && !stream_ready |=> stream_valid && $stable(stream_bit))
    else $error("stalled stream bit lost");
  AST_STREAM_FROM_OP: assert property ($rose(stream_valid) |->
    !serializer_ready || !$past(serializer_ready) || !$past(serializer_ready, 2))
    else $error("stream bit without operation");
endmodule
bind programmable_lfsr_unit programmable_lfsr_unit_chk #(.UNIT_ID(UNIT_ID), .BUF_DEPTH(BUF_DEPTH))
  programmable_lfsr_unit_chk_inst (.clock(clock), .nrst(nrst), .clock_enable(clock_enable),
  .bus_write(bus_write), .bus_read(bus_read), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .serializer_load(serializer_load),
  .serializer_receive_buffer(serializer_receive_buffer), .serializer_ready(serializer_ready),
  .stream_bit(stream_bit), .stream_valid(stream_valid), .stream_ready(stream_ready));
`default_nettype wire

// [verification/tb_programmable_lfsr_unit.sv]
// self-checking bench for the lfsr unit
`default_nettype none
module tb_programmable_lfsr_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clock_enable = 1'b1;
  logic bus_write = 1'b0;
  logic bus_read = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic bus_rvalid;
  logic serializer_load = 1'b0;
  logic [15:0] serializer_receive_buffer = 16'h0000;
  logic serializer_ready;
  logic stream_bit;
  logic stream_valid;
  logic stream_ready = 1'b1;
  int err_total = 0;
  int compares = 0;
  int pops = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [15:0] stream_seen = 16'h0000;
  logic [7:0] rst_h [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'hFF, 8'hFF};
  logic [7:0] rst_l [13] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
  programmable_lfsr_unit #(.UNIT_ID(4'h0), .BUF_DEPTH(2)) programmable_lfsr_unit_inst (.clock(clock), .nrst(nrst),
    .clock_enable(clock_enable), .bus_write(bus_write), .bus_read(bus_read), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .serializer_load(serializer_load),
    .serializer_receive_buffer(serializer_receive_buffer), .serializer_ready(serializer_ready),
    .stream_bit(stream_bit), .stream_valid(stream_valid), .stream_ready(stream_ready));
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (stream_valid === 1'b1 && stream_ready === 1'b1) begin
      pops++;
      stream_seen = {stream_seen[14:0], stream_bit};
    end
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_read <= 1'b0;
    #1;
    rv = bus_rdata;
    check({15'h0000, bus_rvalid}, 16'h0001);
  endtask
  task automatic pair(input logic [7:0] idx, input logic [7:0] h, input logic [7:0] l);
    wr(8'h2B, idx);
    rd(8'h23);
    check({8'h00, rv}, {8'h00, h});
    rd(8'h27);
    check({8'h00, rv}, {8'h00, l});
  endtask
  task automatic wpair(input logic [7:0] idx, input logic [7:0] h, input logic [7:0] l);
    wr(8'h2B, idx);
    wr(8'h23, h);
    wr(8'h27, l);
  endtask
  task automatic waitdone();
    wr(8'h2B, 8'h08);
    for (int i = 0; i < 60; i++) begin
      rd(8'h23);
      if (rv[5] === 1'b1) break;
    end
    check({15'h0000, rv[5]}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 13; i++) begin
      pair(i[7:0], rst_h[i], rst_l[i]);
    end
    pair(8'h0D, 8'h00, 8'h00);
    pair(8'h14, 8'h00, 8'h00);
    wpair(8'h09, 8'hA5, 8'h5A);
    pair(8'h09, 8'hA5, 8'h5A);
    wpair(8'h02, 8'h27, 8'h05);
    pair(8'h02, 8'h27, 8'h05);
    wpair(8'h09, 8'h00, 8'h00);
    wpair(8'h05, 8'hC3, 8'h3C);
    pair(8'h05, 8'hC3, 8'h3C);
    wpair(8'h08, 8'h43, 8'h00);
    pair(8'h05, 8'hFF, 8'hFF);
    // plain shift of four steps, no sources enabled
    pops = 0;
    wpair(8'h00, 8'h00, 8'h00);
    waitdone();
    pair(8'h08, 8'h33, 8'h00);
    pair(8'h05, 8'hFF, 8'hF0);
    pair(8'h01, 8'hF0, 8'h00);
    check(pops[15:0], 16'h0004);
    // input bit into entry, both orders
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h03, 8'h10, 8'hFF);
    wpair(8'h00, 8'h00, 8'h05);
    waitdone();
    pair(8'h05, 8'hFF, 8'hFA);
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h07, 8'h04, 8'h00);
    wpair(8'h00, 8'h00, 8'h05);
    waitdone();
    pair(8'h05, 8'hFF, 8'hF0);
    // high byte as trigger
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h07, 8'h08, 8'h00);
    wr(8'h2B, 8'h00);
    wr(8'h27, 8'h05);
    pair(8'h05, 8'hFF, 8'hFF);
    wr(8'h2B, 8'h00);
    wr(8'h23, 8'h00);
    waitdone();
    pair(8'h05, 8'hFF, 8'hFA);
    // receiver stall holds the shift
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h07, 8'h00, 8'h00);
    stream_ready <= 1'b0;
    pops = 0;
    wpair(8'h00, 8'h00, 8'h05);
    repeat (20) @(posedge clock);
    pair(8'h08, 8'h13, 8'h00);
    stream_ready <= 1'b1;
    waitdone();
    check(pops[15:0], 16'h0004);
    pair(8'h05, 8'hFF, 8'hFA);
    // auto fill with a mismatching compare value
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h03, 8'h12, 8'hFF);
    wpair(8'h0C, 8'hFF, 8'h00);
    wpair(8'h07, 8'h01, 8'h00);
    #1 check({15'h0000, serializer_ready}, 16'h0001);
    @(posedge clock);
    serializer_receive_buffer <= 16'h0005;
    serializer_load <= 1'b1;
    @(posedge clock);
    serializer_load <= 1'b0;
    waitdone();
    pair(8'h05, 8'hFF, 8'hFA);
    pair(8'h08, 8'h23, 8'h00);
    check({12'h000, stream_seen[3:0]}, 16'h000A);
    // direction set: shift toward lsb, byte view reversed
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h0C, 8'hFF, 8'hFF);
    wpair(8'h03, 8'h00, 8'hFF);
    wpair(8'h07, 8'h02, 8'h00);
    wpair(8'h00, 8'h00, 8'h00);
    waitdone();
    pair(8'h05, 8'hFF, 8'hF0);
    pair(8'h08, 8'h33, 8'h00);
    // polynomial add from input and tap one, stream from output tap and tap one
    wpair(8'h08, 8'h43, 8'h00);
    wpair(8'h07, 8'h00, 8'h00);
    wpair(8'h0A, 8'h00, 8'h05);
    wpair(8'h02, 8'h00, 8'h27);
    wpair(8'h03, 8'h85, 8'hFF);
    wpair(8'h00, 8'h00, 8'h05);
    waitdone();
    pair(8'h05, 8'hFF, 8'hE1);
    pair(8'h08, 8'h33, 8'h00);
    check({12'h000, stream_seen[3:0]}, 16'h0005);
    conclude();
  end
endmodule
`default_nettype wire
